// file: core/vovr_map.svh
// Command codes, field positions, reset values and timing counts of the overvoltage response.
`ifndef VOVR_MAP_SVH
`define VOVR_MAP_SVH

// Command codes as seen on the decoded command port, and the all-pages value of the page port.
`define VOVR_CMD_RESP        8'h41
`define VOVR_CMD_RETRY       8'hDB
`define VOVR_PAGE_ALL        8'hFF

// Field positions inside the response byte.
`define VOVR_RESP_HI         7
`define VOVR_RESP_LO         6
`define VOVR_RETRY_HI        5
`define VOVR_RETRY_LO        3
`define VOVR_DLY_HI          2
`define VOVR_DLY_LO          0

// Field codes and recognised whole-byte codes.
`define VOVR_RETRY_NONE      3'h0
`define VOVR_RETRY_ALWAYS    3'h7
`define VOVR_CODE_CLAMP      8'h00
`define VOVR_CODE_OFF        8'h80
`define VOVR_CODE_OFF_RETRY  8'hB8
`define VOVR_FAM_DGL_OFF     5'h08
`define VOVR_FAM_DGL_RETRY   5'h0F

// Reset values.
`define VOVR_RESP_RST        8'hB8
`define VOVR_RETRY_RST_MS    16'h015E

// Timing: clock rate, deglitch step and the derived cycle counts.
`define VOVR_CLK_HZ          40000000
`define VOVR_DGL_STEP_US     10
`define VOVR_DGL_STEP_CYC    ((`VOVR_CLK_HZ / 1000000) * `VOVR_DGL_STEP_US)
`define VOVR_MS_CYC          (`VOVR_CLK_HZ / 1000)

`endif

// file: core/vovr_pkg.sv
// Types shared by the overvoltage response logic.
package vovr_pkg;

   typedef enum logic [2:0] {
      VOVR_ST_RUN      = 3'b000,
      VOVR_ST_DEGLITCH = 3'b001,
      VOVR_ST_CLAMP    = 3'b010,
      VOVR_ST_LATCHED  = 3'b011,
      VOVR_ST_RETRY    = 3'b100
   } vovr_state_e;

   typedef enum logic [1:0] {
      VOVR_RSP_CLAMP    = 2'b00,
      VOVR_RSP_DEGLITCH = 2'b01,
      VOVR_RSP_SHUTDOWN = 2'b10,
      VOVR_RSP_BAD      = 2'b11
   } vovr_resp_e;

   typedef logic [7:0]  vovr_byte_t;
   typedef logic [15:0] vovr_word_t;

endpackage

// file: core/vovr_core.sv
// Output overvoltage fault response: setting, deglitch, clamp, shutdown and retry.
//
// Functional notes
// - Overvoltage sets the byte, word and vout status bits.
// - Overvoltage raises the alert pin unless masked.
// - Code 0x00 clamps only, never shuts down.
// - Clamp: high side off, low side on.
// - Code 0x80 disables at once, no restart.
// - Code 0xB8 disables, then retries without limit.
// - Codes 0x4n latch off until cycled or reset.
// - Codes 0x78+n shut down, retry until cleared.
// - Deglitched codes act after n times 10 us.
// - Unknown code ignored and raises a CML fault.
// - Status clears on clear, off-on or power.
// - Field 01 keeps running for the delay first.
// - Field 10 disables immediately, then follows retry.
// - Field 11 is unsupported and flags CML.
// - Retry 000 stays off until off; clear releases field 10 only.
// - Retry 111 restarts, spaced by the interval.
// - Bits 2:0 give delay in 10 us steps.
// - Setting is paged byte 0x41, default 0xB8.
// - Retry interval is separate, default 350 ms.

`timescale 1ns/1ps

`include "vovr_map.svh"

module vovr_core
   import vovr_pkg::*;
#(
   parameter logic [7:0] P_PAGE      = 8'h00,
   parameter int         P_MS_CYCLES = `VOVR_MS_CYC
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_wr_stb,
   input  wire logic [7:0]  i_page,
   input  wire logic [7:0]  i_cmd_code,
   input  wire logic [15:0] i_wr_data,
   input  wire logic        i_output_overvoltage_flag,
   input  wire logic        i_run_pin,
   input  wire logic        i_op_on,
   input  wire logic        i_clear_faults,
   input  wire logic        i_reset_cmd,
   input  wire logic        i_alert_mask,
   input  wire logic        i_hard_fault,
   output logic [7:0]       o_resp_setting,
   output logic [15:0]      o_restart_interval_setting,
   output logic             o_cml_fault,
   output logic             o_status_byte_ov,
   output logic             o_status_word_vout,
   output logic             o_status_output_overvoltage_flag,
   output logic             o_alert_n_out,
   output logic             o_alert_oe_n,
   output logic             o_hs_drive_en,
   output logic             o_overvoltage_low_side_clamp,
   output logic             o_chan_off,
   output logic             o_retry_pending
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Only the five documented code groups are accepted.
   function automatic logic code_ok(input vovr_byte_t b);
      logic [4:0] fam;
      fam = b[7:3];
      code_ok = (b == `VOVR_CODE_CLAMP)
             || (b == `VOVR_CODE_OFF)
             || (b == `VOVR_CODE_OFF_RETRY)
             || (fam == `VOVR_FAM_DGL_OFF)
             || (fam == `VOVR_FAM_DGL_RETRY);
   endfunction

   // Deglitch length in clock cycles for a delay count n.
   function automatic logic [11:0] dgl_limit(input logic [2:0] n);
      logic [11:0] step;
      step = 12'(`VOVR_DGL_STEP_CYC);
      dgl_limit = 12'(n * step);
   endfunction

   // ************************************************************
   // Declarations
   // ************************************************************

   logic        ov_s1_r;
   logic        ov_s2_r;
   logic        run_s1_r;
   logic        run_s2_r;
   logic        en_prev_r;

   vovr_byte_t  resp_r;
   vovr_byte_t  resp_nxt;
   vovr_word_t  retry_ms_r;
   vovr_word_t  retry_ms_nxt;
   logic        cml_r;
   logic        cml_nxt;

   vovr_state_e state_r;
   vovr_state_e state_nxt;
   logic [11:0] dgl_r;
   logic [11:0] dgl_nxt;
   logic [15:0] tick_r;
   logic [15:0] tick_nxt;
   logic [15:0] ms_r;
   logic [15:0] ms_nxt;

   logic        stat_r;
   logic        stat_nxt;
   logic        alert_r;
   logic        alert_nxt;
   logic        hs_r;
   logic        clamp_r;
   logic        off_r;
   logic        pend_r;

   // ************************************************************
   // Decode
   // ************************************************************

   wire         page_hit  = (i_page == P_PAGE) || (i_page == `VOVR_PAGE_ALL);
   wire         wr_resp   = i_wr_stb && page_hit && (i_cmd_code == `VOVR_CMD_RESP);
   wire         wr_retry  = i_wr_stb && page_hit && (i_cmd_code == `VOVR_CMD_RETRY);
   wire         wr_ok     = code_ok(i_wr_data[7:0]);

   wire         en_now    = run_s2_r && i_op_on;
   wire         en_rise   = en_now && !en_prev_r;

   wire vovr_resp_e resp_sel = vovr_resp_e'(resp_r[`VOVR_RESP_HI:`VOVR_RESP_LO]);
   wire [2:0]   retry_fld = resp_r[`VOVR_RETRY_HI:`VOVR_RETRY_LO];
   wire [2:0]   dly_n     = resp_r[`VOVR_DLY_HI:`VOVR_DLY_LO];
   wire [11:0]  dgl_max   = dgl_limit(dly_n);
   wire         retry_all = (retry_fld == `VOVR_RETRY_ALWAYS);

   // A shutdown ends in retry only for the all-ones retry field.
   wire vovr_state_e shut_tgt = retry_all ? VOVR_ST_RETRY : VOVR_ST_LATCHED;

   wire         tick_wrap = (tick_r == 16'(P_MS_CYCLES - 1));
   wire         retry_due = (ms_r >= retry_ms_r);

   // ************************************************************
   // Setting registers
   // ************************************************************

   // A rejected byte leaves the stored setting untouched; the field value 11 is
   // never in the accepted set, so it always lands here.
   assign resp_nxt     = (wr_resp && wr_ok) ? i_wr_data[7:0] : resp_r;
   assign cml_nxt      = wr_resp && !wr_ok;

   // The interval arrives already converted to whole milliseconds.
   assign retry_ms_nxt = wr_retry ? i_wr_data : retry_ms_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         resp_r     <= `VOVR_RESP_RST;
         retry_ms_r <= `VOVR_RETRY_RST_MS;
         cml_r      <= 1'b0;
      end else begin
         resp_r     <= resp_nxt;
         retry_ms_r <= retry_ms_nxt;
         cml_r      <= cml_nxt;
      end
   end

   // ************************************************************
   // Input synchronisers
   // ************************************************************

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ov_s1_r   <= 1'b0;
         ov_s2_r   <= 1'b0;
         run_s1_r  <= 1'b0;
         run_s2_r  <= 1'b0;
         en_prev_r <= 1'b0;
      end else begin
         ov_s1_r   <= i_output_overvoltage_flag;
         ov_s2_r   <= ov_s1_r;
         run_s1_r  <= i_run_pin;
         run_s2_r  <= run_s1_r;
         en_prev_r <= en_now;
      end
   end

   // ************************************************************
   // Response state machine
   // ************************************************************

   // Turning the channel off always returns to run, so a later on edge is the
   // off-then-on cycle that releases a latched shutdown.
   always_comb begin
      state_nxt = state_r;
      dgl_nxt   = 12'h000;
      if (i_reset_cmd || !en_now) begin
         state_nxt = VOVR_ST_RUN;
      end else if (i_hard_fault) begin
         state_nxt = VOVR_ST_LATCHED;
      end else begin
         unique case (state_r)
            VOVR_ST_RUN: begin
               if (ov_s2_r) begin
                  unique case (resp_sel)
                     VOVR_RSP_CLAMP: begin
                        state_nxt = VOVR_ST_CLAMP;
                     end
                     VOVR_RSP_DEGLITCH: begin
                        if (dgl_max <= 12'h001) begin
                           state_nxt = shut_tgt;
                        end else begin
                           state_nxt = VOVR_ST_DEGLITCH;
                           dgl_nxt   = 12'h001;
                        end
                     end
                     VOVR_RSP_SHUTDOWN: begin
                        state_nxt = shut_tgt;
                     end
                     VOVR_RSP_BAD: begin
                        state_nxt = shut_tgt;
                     end
                  endcase
               end
            end
            VOVR_ST_DEGLITCH: begin
               if (!ov_s2_r) begin
                  state_nxt = VOVR_ST_RUN;
               end else if (dgl_r + 12'h001 >= dgl_max) begin
                  state_nxt = shut_tgt;
               end else begin
                  dgl_nxt = dgl_r + 12'h001;
               end
            end
            VOVR_ST_CLAMP: begin
               if (!ov_s2_r) begin
                  state_nxt = VOVR_ST_RUN;
               end
            end
            VOVR_ST_LATCHED: begin
               // Only a field 10 setting (0x80 or 0xB8) is released by a fault clear.
               if (i_clear_faults && resp_sel == VOVR_RSP_SHUTDOWN) begin
                  state_nxt = VOVR_ST_RUN;
               end
            end
            VOVR_ST_RETRY: begin
               if (retry_due || i_clear_faults) begin
                  state_nxt = VOVR_ST_RUN;
               end
            end
            default: begin
               state_nxt = VOVR_ST_RUN;
            end
         endcase
      end
   end

   // ************************************************************
   // Retry interval timer
   // ************************************************************

   // The interval runs from the moment of shutdown; leaving the wait clears it.
   always_comb begin
      tick_nxt = 16'h0000;
      ms_nxt   = 16'h0000;
      if (state_r == VOVR_ST_RETRY && state_nxt == VOVR_ST_RETRY) begin
         tick_nxt = tick_wrap ? 16'h0000 : tick_r + 16'h0001;
         ms_nxt   = tick_wrap ? ms_r + 16'h0001 : ms_r;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= VOVR_ST_RUN;
         dgl_r   <= 12'h000;
         tick_r  <= 16'h0000;
         ms_r    <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         dgl_r   <= dgl_nxt;
         tick_r  <= tick_nxt;
         ms_r    <= ms_nxt;
      end
   end

   // ************************************************************
   // Status and alert
   // ************************************************************

   // Set has priority, so a fault still present when the clear arrives is kept.
   wire stat_clr = i_clear_faults || en_rise || i_reset_cmd;

   assign stat_nxt  = ov_s2_r || (stat_r && !stat_clr);
   assign alert_nxt = (ov_s2_r && !i_alert_mask) || (alert_r && !stat_clr);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         stat_r  <= 1'b0;
         alert_r <= 1'b0;
      end else begin
         stat_r  <= stat_nxt;
         alert_r <= alert_nxt;
      end
   end

   // ************************************************************
   // Switch drive outputs
   // ************************************************************

   // High side stays allowed while deglitching: the channel keeps regulating.
   wire hs_nxt    = en_now && (state_nxt == VOVR_ST_RUN || state_nxt == VOVR_ST_DEGLITCH);
   wire clamp_nxt = (state_nxt == VOVR_ST_CLAMP);
   wire off_nxt   = !en_now || state_nxt == VOVR_ST_LATCHED
                    || state_nxt == VOVR_ST_RETRY;
   wire pend_nxt  = (state_nxt == VOVR_ST_RETRY);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         hs_r    <= 1'b0;
         clamp_r <= 1'b0;
         off_r   <= 1'b1;
         pend_r  <= 1'b0;
      end else begin
         hs_r    <= hs_nxt;
         clamp_r <= clamp_nxt;
         off_r   <= off_nxt;
         pend_r  <= pend_nxt;
      end
   end

   // ************************************************************
   // Output assignments
   // ************************************************************

   // The alert line is open drain: the data bit is a constant low and only the
   // enable moves, so the line is never driven high.
   logic alert_low_r;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         alert_low_r <= 1'b0;
      end else begin
         alert_low_r <= 1'b0;
      end
   end

   assign o_resp_setting               = resp_r;
   assign o_restart_interval_setting   = retry_ms_r;
   assign o_cml_fault                  = cml_r;
   assign o_status_byte_ov             = stat_r;
   assign o_status_word_vout           = stat_r;
   assign o_status_output_overvoltage_flag             = stat_r;
   assign o_alert_n_out                = alert_low_r;
   assign o_alert_oe_n                 = !alert_r;
   assign o_hs_drive_en                = hs_r;
   assign o_overvoltage_low_side_clamp = clamp_r;
   assign o_chan_off                   = off_r;
   assign o_retry_pending              = pend_r;

endmodule

// file: test/vovr_core_chk.sv
// Assertion checker for the overvoltage response block.
`timescale 1ns/1ps
module vovr_core_chk #(
   parameter logic [7:0] P_PAGE      = 8'h00,
   parameter int         P_MS_CYCLES = 4
) (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_wr_stb,
   input wire logic [7:0]  i_page,
   input wire logic [7:0]  i_cmd_code,
   input wire logic [15:0] i_wr_data,
   input wire logic        i_run_pin,
   input wire logic        i_op_on,
   input wire logic        i_clear_faults,
   input wire logic        i_reset_cmd,
   input wire logic        i_alert_mask,
   input wire logic [7:0]  o_resp_setting,
   input wire logic        o_cml_fault,
   input wire logic        o_alert_n_out,
   input wire logic        o_status_byte_ov,
   input wire logic        o_status_word_vout,
   input wire logic        o_status_output_overvoltage_flag,
   input wire logic        o_alert_oe_n,
   input wire logic        o_hs_drive_en,
   input wire logic        o_overvoltage_low_side_clamp,
   input wire logic        o_chan_off,
   input wire logic        o_retry_pending
);
   // ****
   // Write decode and properties
   // ****
   logic [7:0] data_r;
   wire  [7:0] d   = i_wr_data[7:0];
   wire        hit = i_wr_stb && i_cmd_code == 8'h41 && (i_page == P_PAGE || i_page == 8'hFF);
   wire        known = d == 8'h00 || d == 8'h80 || d == 8'hB8 || d[7:3] == 5'h08
                       || d[7:3] == 5'h0F;
   always_ff @(posedge i_mclk) data_r <= d;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_bad_wr; hit && !known; endsequence
   sequence s_good_wr; hit && known; endsequence
   // Six steady cycles let the synchronised run pin settle before stickiness is judged.
   sequence s_on; (i_run_pin && i_op_on) [*6]; endsequence
   property p_reset_val; $past(i_rst) |-> o_resp_setting == 8'hB8 && o_chan_off; endproperty
   property p_bad_wr; s_bad_wr |=> o_cml_fault && $stable(o_resp_setting); endproperty
   property p_bad_field; s_bad_wr ##0 (d[7:6] == 2'b11) |=> o_cml_fault; endproperty
   property p_good_wr; s_good_wr |=> !o_cml_fault && o_resp_setting == data_r; endproperty
   property p_status_tie;
      o_status_byte_ov == o_status_output_overvoltage_flag && o_status_word_vout == o_status_output_overvoltage_flag;
   endproperty
   property p_alert; $rose(o_status_output_overvoltage_flag) && !i_alert_mask |-> !o_alert_oe_n; endproperty
   property p_clamp;
      o_overvoltage_low_side_clamp |-> !o_hs_drive_en && !o_chan_off && o_resp_setting == 8'h00;
   endproperty
   property p_sticky;
      s_on ##0 (o_status_output_overvoltage_flag && !i_clear_faults && !i_reset_cmd) |=> o_status_output_overvoltage_flag;
   endproperty
   property p_retry; o_retry_pending |-> o_chan_off && !o_hs_drive_en; endproperty
   property p_alert_pin; !o_alert_oe_n |-> !o_alert_n_out; endproperty
   a_reset_val: assert property (p_reset_val) else $error("bad setting after reset");
   a_bad_wr: assert property (p_bad_wr) else $error("bad write not refused");
   a_bad_field: assert property (p_bad_field) else $error("field 11 accepted");
   a_good_wr: assert property (p_good_wr) else $error("good write not stored");
   a_status_tie: assert property (p_status_tie) else $error("status bits differ");
   a_alert: assert property (p_alert) else $error("alert not raised");
   a_clamp: assert property (p_clamp) else $error("clamp drive wrong");
   a_sticky: assert property (p_sticky) else $error("status cleared early");
   a_retry: assert property (p_retry) else $error("retry wait not off");
   a_alert_pin: assert property (p_alert_pin) else $error("alert pin driven high");
endmodule
bind vovr_core vovr_core_chk #(.P_PAGE(P_PAGE), .P_MS_CYCLES(P_MS_CYCLES)) u_chk (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_wr_stb(i_wr_stb), .i_page(i_page),
   .i_cmd_code(i_cmd_code), .i_wr_data(i_wr_data), .i_run_pin(i_run_pin),
   .i_op_on(i_op_on), .i_clear_faults(i_clear_faults), .i_reset_cmd(i_reset_cmd),
   .i_alert_mask(i_alert_mask), .o_resp_setting(o_resp_setting), .o_cml_fault(o_cml_fault),
   .o_alert_n_out(o_alert_n_out),
   .o_status_byte_ov(o_status_byte_ov), .o_status_word_vout(o_status_word_vout),
   .o_status_output_overvoltage_flag(o_status_output_overvoltage_flag), .o_alert_oe_n(o_alert_oe_n),
   .o_hs_drive_en(o_hs_drive_en), .o_overvoltage_low_side_clamp(o_overvoltage_low_side_clamp),
   .o_chan_off(o_chan_off), .o_retry_pending(o_retry_pending)
);

// file: test/vovr_host.sv
// Host model issuing decoded configuration writes.
`timescale 1ns/1ps
module vovr_host (
   input  wire logic        i_mclk,
   output logic             o_wr_stb,
   output logic [7:0]       o_page,
   output logic [7:0]       o_cmd_code,
   output logic [15:0]      o_wr_data
);
   initial begin
      o_wr_stb   = 1'b0;
      o_page     = 8'h00;
      o_cmd_code = 8'h00;
      o_wr_data  = 16'h0000;
   end
   task automatic write(input logic [7:0] pg, input logic [7:0] c, input logic [15:0] dt);
      @(negedge i_mclk);
      o_wr_stb   = 1'b1;
      o_page     = pg;
      o_cmd_code = c;
      o_wr_data  = dt;
      @(negedge i_mclk);
      o_wr_stb   = 1'b0;
      // Released lines carry junk so a stale value can never pass for a write.
      o_cmd_code = ~c;
      o_wr_data  = ~dt;
   endtask
endmodule

// file: test/test_vovr_core.sv
// Self-checking bench for the overvoltage response block.
`timescale 1ns/1ps
module test_vovr_core;
   logic        mclk, rst, ov, run, op, clr, mask, hard, rcmd;
   wire         stb, cml, sb, sw, sv, an, aoe, hs, clamp, off, pend;
   wire  [7:0]  page, code, rset;
   wire  [15:0] wdata, rint;
   wire  [30:0] got = {rint, rset, off, hs, clamp, sv, aoe, pend, cml};
   logic [61:0] q[$];
   logic [31:0] seed = 32'h00000029;
   logic [31:0] r;
   logic [7:0]  d, cur;
   logic [7:0]  tbl[6] = '{8'hC0, 8'h48, 8'h77, 8'h47, 8'h7F, 8'hFF};
   int          fail_count = 0;
   int          cmp_count = 0;
   event        ev;
   vovr_host host (.i_mclk(mclk), .o_wr_stb(stb), .o_page(page), .o_cmd_code(code),
      .o_wr_data(wdata));
   vovr_core #(.P_MS_CYCLES(4)) dut (
      .i_mclk(mclk), .i_rst(rst), .i_wr_stb(stb), .i_page(page), .i_cmd_code(code),
      .i_wr_data(wdata), .i_output_overvoltage_flag(ov), .i_run_pin(run), .i_op_on(op),
      .i_clear_faults(clr), .i_reset_cmd(rcmd), .i_alert_mask(mask), .i_hard_fault(hard),
      .o_resp_setting(rset), .o_restart_interval_setting(rint), .o_cml_fault(cml),
      .o_status_byte_ov(sb), .o_status_word_vout(sw), .o_status_output_overvoltage_flag(sv),
      .o_alert_n_out(an), .o_alert_oe_n(aoe), .o_hs_drive_en(hs),
      .o_overvoltage_low_side_clamp(clamp), .o_chan_off(off), .o_retry_pending(pend));
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic ok(input logic [7:0] v);
      return v == 8'h00 || v == 8'h80 || v == 8'hB8 || v[7:3] == 5'h08 || v[7:3] == 5'h0F;
   endfunction
   task automatic ex(input logic [30:0] e, input logic [30:0] m);
      q.push_back({e, m});
      ->ev;
   endtask
   task automatic exf(input logic [6:0] e, input logic [6:0] m);
      ex({24'h000000, e}, {24'h000000, m});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic ovp();
      ov = 1'b1;
      cyc(1);
      ov = 1'b0;
   endtask
   task automatic recyc();
      op = 1'b0;
      cyc(3);
      op = 1'b1;
      cyc(5);
   endtask
   task automatic clear();
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(2);
   endtask
   task automatic done(input string s);
      $display("test %s done: %0d checks, %0d mismatches", s, cmp_count, fail_count);
   endtask
   task automatic cmp(input logic [30:0] g, input logic [30:0] e, input logic [30:0] m);
      cmp_count++;
      if ((g & m) !== (e & m)) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h mask %h", $time, g, e, m);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial forever begin
      @(ev);
      cmp(got, q[0][61:31], q[0][30:0]);
      void'(q.pop_front());
   end
   // The tests need about 2900 cycles; the limit leaves ample margin.
   initial begin
      #(25 * 10000);
      fail_count++;
      final_report();
   end
   initial begin
      {ov, run, op, clr, mask, hard, rcmd} = 7'h00;
      rst = 1'b1;
      cur = 8'hB8;
      cyc(8);
      rst = 1'b0;
      cyc(1);
      ex({16'h015E, 8'hB8, 7'b1000100}, 31'h7FFFFFFF);
      run = 1'b1;
      op = 1'b1;
      cyc(5);
      exf(7'b0100100, 7'h7F);
      done("reset");
      for (int i = 0; i < 26; i++) begin
         r = xs();
         d = (i < 6) ? tbl[i] : r[7:0];
         host.write(i[0] ? 8'hFF : 8'h00, 8'h41, {r[15:8], d});
         if (ok(d)) cur = d;
         ex({16'h015E, cur, 6'h00, !ok(d)}, {16'h0000, 8'hFF, 7'h01});
      end
      host.write(8'h01, 8'h41, 16'h0080);
      host.write(8'h00, 8'hDB, 16'h0001);
      ex({16'h0001, cur, 7'h00}, {16'hFFFF, 8'hFF, 7'h01});
      done("writes");
      host.write(8'h00, 8'h41, 16'h0000);
      ov = 1'b1;
      cyc(4);
      exf(7'b0011000, 7'h7F);
      cyc(300);
      exf(7'b0011000, 7'h7F);
      ov = 1'b0;
      cyc(4);
      exf(7'b0101000, 7'h7B);
      clear();
      exf(7'b0100000, 7'h7B);
      mask = 1'b1;
      ov = 1'b1;
      cyc(4);
      exf(7'b0011100, 7'h7F);
      ov = 1'b0;
      // Unmask only once the fault has left the synchroniser, or the alert fires late.
      cyc(3);
      mask = 1'b0;
      clear();
      exf(7'b0100100, 7'h7F);
      done("clamp");
      host.write(8'h00, 8'h41, 16'h0080);
      ovp();
      cyc(5);
      exf(7'b1001000, 7'h7B);
      cyc(100);
      exf(7'b1001000, 7'h7B);
      clear();
      exf(7'b0100000, 7'h7B);
      recyc();
      exf(7'b0100000, 7'h7B);
      done("off");
      host.write(8'h00, 8'h41, 16'h00B8);
      ovp();
      cyc(4);
      exf(7'b1001010, 7'h7B);
      cyc(12);
      exf(7'b0101000, 7'h7B);
      hard = 1'b1;
      ovp();
      cyc(30);
      exf(7'b1000000, 7'h62);
      hard = 1'b0;
      recyc();
      done("retry");
      host.write(8'h00, 8'h41, 16'h0043);
      ov = 1'b1;
      cyc(1000);
      exf(7'b0100000, 7'h60);
      ov = 1'b0;
      cyc(10);
      ov = 1'b1;
      cyc(1150);
      exf(7'b0100000, 7'h60);
      cyc(110);
      exf(7'b1000000, 7'h60);
      ov = 1'b0;
      clear();
      exf(7'b1000000, 7'h40);
      rcmd = 1'b1;
      cyc(1);
      rcmd = 1'b0;
      cyc(2);
      exf(7'b0100000, 7'h68);
      recyc();
      exf(7'b0100000, 7'h60);
      done("deglitch");
      host.write(8'h00, 8'h41, 16'h0078);
      ovp();
      cyc(4);
      exf(7'b1000010, 7'h62);
      cyc(12);
      exf(7'b0100000, 7'h62);
      done("deglitch retry");
      cyc(2);
      final_report();
   end
endmodule
